// ==== hw/flash_erase_power_seq.sv ====
// erase, deep sleep and id command sequencer of a serial flash
// Contract
// RL1: 52h plus three address bytes erases 32k
// RL2: d8h plus three address bytes erases 64k
// RL3: 60h or c7h erases array, no address
// RL4: host sets write latch before any erase
// RL5: host holds select low whole sequence
// RL6: block erase only if frame ends exactly
// RL7: array erase, sleep only after eight bits
// RL8: select rise starts erase, busy until done
// RL9: write latch cleared before erase completes
// RL10: protected block is never erased
// RL11: array erase needs low protect bits zero
// RL12: b9h alone enters sleep after delay
// RL13: sleep ignores all but wake command
// RL14: sleep request during busy is rejected
// RL15: idle deselect means plain standby
// RL16: reset always starts in standby
// RL17: abh alone releases sleep
// RL18: no command accepted during wake recovery
// RL19: abh plus dummies repeats device id
// RL20: abh ignored while busy
// RL21: 90h address zero gives maker then device
// RL22: 90h address one gives device first
// RL23: 90h id bytes alternate while clocked
// RL24: timed phases are counted cycle parameters
`timescale 1ns/100ps
module flash_erase_power_seq
  import flash_cmd_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = MAKER_ID_DEFAULT, // arbitrary value
  parameter logic [7:0] DEVICE_ID = DEVICE_ID_DEFAULT, // arbitrary value
  parameter int ERASE_32K_CYCLES = ERASE_32K_CYC,
  parameter int ERASE_64K_CYCLES = ERASE_64K_CYC,
  parameter int ARRAY_ERASE_CYCLES = ARRAY_ERASE_CYC
) (
  input logic core_clk_i,
  input logic rst_i,
  input logic spi_sclk_i,
  input logic spi_cs_n_i,
  input logic spi_si_i,
  input logic latch_set_i,
  input logic protect_bit_0_i,
  input logic protect_bit_1_i,
  input logic protect_bit_2_i,
  input logic protect_bit_3_i,
  input logic protect_bit_4_i,
  output logic spi_so_o,
  output logic spi_so_oe_o,
  output logic busy_flag_o,
  output logic write_latch_flag_o,
  output logic deep_sleep_o,
  output erase_kind_t erase_kind_o,
  output logic [23:0] erase_addr_o,
  output logic erase_done_o,
  output logic cmd_drop_o
);
  // link side: clocked by the host clock, framed by select
  logic frame_rst;
  logic in_frame_reg;
  logic [31:0] shift_reg;
  logic [31:0] shift_next;
  logic [5:0] bits_reg;
  logic [5:0] bits_next;
  logic long_reg;
  logic long_next;
  logic [7:0] opcode_reg;
  logic [7:0] opcode_next;
  logic tog_reg;
  logic tog_next;
  logic swap_reg;
  logic swap_next;
  id_mode_t id_mode_reg;
  id_mode_t id_mode_next;
  logic [2:0] link_stat;
  logic so_reg;
  logic so_next;
  logic so_oe_reg;
  logic so_oe_next;
  logic [5:0] out_idx;
  logic [7:0] out_byte;
  // core side
  logic [1:0] core_in;
  logic cs_q_reg;
  logic seen_tog_reg;
  logic seen_tog_next;
  logic frame_end;
  power_state_t state_reg;
  power_state_t state_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic latch_reg;
  logic latch_next;
  logic busy_reg;
  logic asleep_reg;
  logic quiet_reg;
  logic done_reg;
  logic done_next;
  logic drop_reg;
  logic drop_next;
  erase_kind_t kind_reg;
  erase_kind_t kind_next;
  logic [23:0] addr_reg;
  logic [23:0] addr_next;
  logic op8;
  logic op32;
  logic cmd_seen;
  logic is_blk;
  logic is_all;
  logic [2:0] bp_low;
  logic [4:0] blk_idx;
  logic [4:0] blk_rank;
  logic [6:0] prot_blocks;
  logic blk_prot;
  logic all_locked;
  logic erase_go;

  // select high clears the frame; also ends the output drive
  assign frame_rst = rst_i | spi_cs_n_i;

  always_ff @(posedge spi_sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      in_frame_reg <= 1'b0;
    end else begin
      in_frame_reg <= 1'b1;
    end
  end

  // core status seen by the link; only changes between frames in normal use
  level_sync #(.WIDTH(3), .RST_VAL(3'h0)) link_sync (
    .clk_i(spi_sclk_i),
    .rst_i(rst_i),
    .d_i({busy_reg, asleep_reg, quiet_reg}),
    .q_o(link_stat)
  );

  always_comb begin
    shift_next = {shift_reg[30:0], spi_si_i};
    bits_next = (bits_reg == FRAME_WRAP_HI) ? FRAME_OP_ADDR : bits_reg + 6'h01;
    long_next = long_reg | (bits_reg >= FRAME_OP_ADDR);
    tog_next = tog_reg;
    opcode_next = opcode_reg;
    id_mode_next = id_mode_reg;
    swap_next = swap_reg;
    if (!in_frame_reg) begin
      shift_next = {31'h0, spi_si_i};
      bits_next = 6'h01;
      long_next = 1'b0;
      tog_next = ~tog_reg;
      id_mode_next = ID_NONE;
      swap_next = 1'b0;
    end
    if (bits_next == FRAME_OP_ONLY && !long_next) begin
      opcode_next = shift_next[7:0];
      if (opcode_next == OP_WAKE_ID && !link_stat[2] && !(link_stat[0] && !link_stat[1])) begin
        id_mode_next = ID_DEVICE; // RL19 RL20 RL18
      end else if (opcode_next == OP_MAKER_ID && link_stat == 3'h0) begin
        id_mode_next = ID_BOTH; // RL21 RL13
      end
    end
    if (bits_next == FRAME_OP_ADDR && !long_next) begin
      swap_next = (shift_next[23:0] == ADDR_ID_SWAP); // RL22
    end
  end

  // shift and opcode are not cleared by select: the core reads them after the frame
  always_ff @(posedge spi_sclk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= 32'h0;
      bits_reg <= 6'h00;
      long_reg <= 1'b0;
      opcode_reg <= 8'h00;
      tog_reg <= 1'b0;
      id_mode_reg <= ID_NONE;
      swap_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      bits_reg <= bits_next;
      long_reg <= long_next;
      opcode_reg <= opcode_next;
      tog_reg <= tog_next;
      id_mode_reg <= id_mode_next;
      swap_reg <= swap_next;
    end
  end

  // output bits leave on the falling edge, msb first, cycling every 8 or 16 bits
  always_comb begin
    out_idx = bits_reg - FRAME_OP_ADDR;
    out_byte = DEVICE_ID;
    if (id_mode_reg == ID_BOTH && (out_idx[3] ^ swap_reg) == 1'b0) begin
      out_byte = MAKER_ID; // RL21 RL23
    end
    so_oe_next = in_frame_reg && id_mode_reg != ID_NONE && (long_reg || bits_reg == FRAME_OP_ADDR);
    so_next = so_oe_next ? out_byte[3'h7 - out_idx[2:0]] : 1'b0; // RL19
  end

  always_ff @(negedge spi_sclk_i or posedge frame_rst) begin
    if (frame_rst) begin
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
    end else begin
      so_reg <= so_next;
      so_oe_reg <= so_oe_next;
    end
  end

  assign spi_so_o = so_reg;
  assign spi_so_oe_o = so_oe_reg;

  // core side: select and frame toggle cross as levels
  level_sync #(.WIDTH(2), .RST_VAL(2'h2)) core_sync (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i({spi_cs_n_i, tog_reg}),
    .q_o(core_in)
  );

  // frame fields are stable once select is high, since the host clock stops
  assign frame_end = core_in[1] && !cs_q_reg && (core_in[0] != seen_tog_reg);

  always_comb begin
    op8 = (bits_reg == FRAME_OP_ONLY) && !long_reg;
    op32 = (bits_reg == FRAME_OP_ADDR) && !long_reg;
    cmd_seen = long_reg || bits_reg >= FRAME_OP_ONLY;
    is_blk = (opcode_reg == OP_ERASE_32K) || (opcode_reg == OP_ERASE_64K); // RL1 RL2
    is_all = (opcode_reg == OP_ERASE_ALL_A) || (opcode_reg == OP_ERASE_ALL_B); // RL3
    bp_low = {protect_bit_2_i, protect_bit_1_i, protect_bit_0_i};
    blk_idx = shift_reg[BLK64_MSB:BLK64_LSB];
    blk_rank = protect_bit_3_i ? blk_idx : ~blk_idx;
    if (bp_low == 3'h0) begin
      prot_blocks = 7'h00;
    end else if (protect_bit_4_i) begin
      prot_blocks = 7'h01;
    end else begin
      prot_blocks = 7'h01 << (bp_low - 3'h1);
    end
    blk_prot = {2'h0, blk_rank} < prot_blocks; // RL10
    all_locked = bp_low != 3'h0; // RL11
    erase_go = latch_reg && ((op32 && is_blk && !blk_prot) || (op8 && is_all && !all_locked)); // RL6 RL7
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = (cnt_reg != 32'h0) ? cnt_reg - 32'h1 : 32'h0;
    kind_next = kind_reg;
    addr_next = addr_reg;
    latch_next = latch_reg;
    seen_tog_next = (core_in[1] && !cs_q_reg) ? core_in[0] : seen_tog_reg;
    case (state_reg)
      ST_IDLE: begin
        // RL15
        if (frame_end && erase_go) begin
          state_next = ST_ERASE; // RL8
          latch_next = 1'b0; // RL9
          addr_next = shift_reg[23:0];
          if (is_all) begin
            kind_next = ERASE_ALL;
            cnt_next = 32'(ARRAY_ERASE_CYCLES); // RL24
          end else if (opcode_reg == OP_ERASE_32K) begin
            kind_next = ERASE_BLK32;
            cnt_next = 32'(ERASE_32K_CYCLES);
          end else begin
            kind_next = ERASE_BLK64;
            cnt_next = 32'(ERASE_64K_CYCLES);
          end
        end else if (frame_end && op8 && opcode_reg == OP_SLEEP) begin
          state_next = ST_SLEEP_ENTRY; // RL12 RL7
          cnt_next = 32'(SLEEP_ENTRY_CYC);
        end else if (frame_end && op8 && opcode_reg == OP_WAKE_ID) begin
          state_next = ST_WAKE; // RL17
          cnt_next = 32'(WAKE_RECOVERY_CYC);
        end
      end
      ST_ERASE: begin
        // frames during the cycle, sleep included, are dropped
        if (cnt_reg <= 32'h1) begin
          state_next = ST_IDLE; // RL8 RL14
          kind_next = ERASE_NONE;
        end
      end
      ST_SLEEP_ENTRY: begin
        if (cnt_reg <= 32'h1) begin
          state_next = ST_SLEEP; // RL12
        end
      end
      ST_SLEEP: begin
        if (frame_end && cmd_seen && opcode_reg == OP_WAKE_ID) begin
          state_next = ST_WAKE; // RL13 RL17
          cnt_next = 32'(WAKE_RECOVERY_CYC);
        end
      end
      ST_WAKE: begin
        if (cnt_reg <= 32'h1) begin
          state_next = ST_IDLE; // RL18
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // a latch set in the clearing cycle survives
    if (latch_set_i) begin
      latch_next = 1'b1;
    end
    done_next = state_reg == ST_ERASE && state_next == ST_IDLE;
    drop_next = frame_end && cmd_seen && (is_blk || is_all || opcode_reg == OP_SLEEP)
      && state_next == state_reg; // RL14
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE; // RL16
      cnt_reg <= 32'h0;
      kind_reg <= ERASE_NONE;
      addr_reg <= 24'h0;
      latch_reg <= 1'b0;
      cs_q_reg <= 1'b1;
      seen_tog_reg <= 1'b0;
      busy_reg <= 1'b0;
      asleep_reg <= 1'b0;
      quiet_reg <= 1'b0;
      done_reg <= 1'b0;
      drop_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      kind_reg <= kind_next;
      addr_reg <= addr_next;
      latch_reg <= latch_next;
      cs_q_reg <= core_in[1];
      seen_tog_reg <= seen_tog_next;
      busy_reg <= state_next == ST_ERASE; // RL8
      asleep_reg <= state_next == ST_SLEEP;
      quiet_reg <= state_next inside {ST_SLEEP_ENTRY, ST_SLEEP, ST_WAKE};
      done_reg <= done_next;
      drop_reg <= drop_next;
    end
  end

  assign busy_flag_o = busy_reg;
  assign write_latch_flag_o = latch_reg;
  assign deep_sleep_o = asleep_reg;
  assign erase_kind_o = kind_reg;
  assign erase_addr_o = addr_reg;
  assign erase_done_o = done_reg;
  assign cmd_drop_o = drop_reg;

  default clocking core_cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_blk_frame_exact: assert property ( // RL6
    frame_end && state_reg == ST_IDLE && is_blk && !op32 |=> !busy_reg)
    else $error("block erase started on a misframed command");

  a_all_frame_exact: assert property ( // RL7
    frame_end && state_reg == ST_IDLE && is_all && !op8 |=> !busy_reg)
    else $error("array erase started on a misframed command");

  a_erase_starts: assert property ( // RL8
    frame_end && state_reg == ST_IDLE && erase_go |=> busy_reg ##0 kind_reg != ERASE_NONE)
    else $error("valid erase did not raise busy");

  a_busy_holds: assert property ( // RL8
    busy_reg && cnt_reg > 32'h1 |=> busy_reg)
    else $error("busy dropped before the count expired");

  a_latch_cleared: assert property ( // RL9
    $rose(busy_reg) |-> !latch_reg || $past(latch_set_i))
    else $error("write latch still set at erase start");

  a_blk_protect: assert property ( // RL10
    frame_end && state_reg == ST_IDLE && is_blk && blk_prot |=> !busy_reg)
    else $error("protected block erased");

  a_all_protect: assert property ( // RL11
    frame_end && state_reg == ST_IDLE && is_all && all_locked |=> !busy_reg)
    else $error("array erase ran with protection set");

  a_sleep_entry: assert property ( // RL12
    state_reg == ST_SLEEP_ENTRY && cnt_reg == 32'h1 |=> asleep_reg ##1 asleep_reg)
    else $error("sleep not entered after the entry delay");

  a_sleep_ignores: assert property ( // RL13
    asleep_reg && frame_end && opcode_reg != OP_WAKE_ID |=> asleep_reg && !busy_reg)
    else $error("command acted on while asleep");

  a_sleep_when_busy: assert property ( // RL14
    busy_reg && cnt_reg > 32'h1 && frame_end |=> busy_reg && !quiet_reg)
    else $error("busy cycle disturbed by a frame");

  a_wake_quiet: assert property ( // RL18
    state_reg == ST_WAKE && frame_end |=> !busy_reg && !asleep_reg)
    else $error("command accepted during wake recovery");

  a_busy_count: assert property ( // RL24
    $rose(busy_reg) |-> cnt_reg == (kind_reg == ERASE_ALL ? 32'(ARRAY_ERASE_CYCLES) :
      kind_reg == ERASE_BLK32 ? 32'(ERASE_32K_CYCLES) : 32'(ERASE_64K_CYCLES)))
    else $error("erase count loaded with the wrong length");
endmodule : flash_erase_power_seq

// ==== hw/level_sync.sv ====
// two flip-flop level synchroniser
`timescale 1ns/100ps
module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input logic clk_i,
  input logic rst_i,
  input logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  // meta_reg feeds q_reg only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= RST_VAL;
      q_reg <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_reg <= meta_reg;
    end
  end

  assign q_o = q_reg;
endmodule : level_sync

// ==== shared/flash_cmd_pkg.sv ====
// opcodes, frame lengths, timing and state types for the flash sequencer
package flash_cmd_pkg;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hd8;
  localparam logic [7:0] OP_ERASE_ALL_A = 8'h60;
  localparam logic [7:0] OP_ERASE_ALL_B = 8'hc7;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE_ID = 8'hab;
  localparam logic [7:0] OP_MAKER_ID = 8'h90;
  localparam logic [23:0] ADDR_ID_SWAP = 24'h000001;
  localparam logic [5:0] FRAME_OP_ONLY = 6'h08;
  localparam logic [5:0] FRAME_OP_ADDR = 6'h20;
  localparam logic [5:0] FRAME_WRAP_HI = 6'h2f;
  localparam int BLK64_LSB = 16;
  localparam int BLK64_MSB = 20;
  localparam logic [7:0] MAKER_ID_DEFAULT = 8'h5a;
  localparam logic [7:0] DEVICE_ID_DEFAULT = 8'h3c;
  localparam int CORE_CLK_MHZ = 50;
  localparam int ERASE_32K_TIME_US = 150000;
  localparam int ERASE_64K_TIME_US = 250000;
  localparam int ARRAY_ERASE_TIME_US = 8000000;
  localparam int SLEEP_ENTRY_DELAY_NS = 3000;
  localparam int WAKE_RECOVERY_DELAY_NS = 3000;
  localparam int ERASE_32K_CYC = ERASE_32K_TIME_US * CORE_CLK_MHZ;
  localparam int ERASE_64K_CYC = ERASE_64K_TIME_US * CORE_CLK_MHZ;
  localparam int ARRAY_ERASE_CYC = ARRAY_ERASE_TIME_US * CORE_CLK_MHZ;
  localparam int SLEEP_ENTRY_RAW = SLEEP_ENTRY_DELAY_NS * CORE_CLK_MHZ / 1000;
  localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_RAW < 1) ? 1 : SLEEP_ENTRY_RAW;
  localparam int WAKE_RECOVERY_RAW = WAKE_RECOVERY_DELAY_NS * CORE_CLK_MHZ / 1000;
  localparam int WAKE_RECOVERY_CYC = (WAKE_RECOVERY_RAW < 1) ? 1 : WAKE_RECOVERY_RAW;
  typedef enum logic [2:0] {ST_IDLE, ST_ERASE, ST_SLEEP_ENTRY, ST_SLEEP, ST_WAKE} power_state_t;
  typedef enum logic [1:0] {ERASE_NONE, ERASE_BLK32, ERASE_BLK64, ERASE_ALL} erase_kind_t;
  typedef enum logic [1:0] {ID_NONE, ID_DEVICE, ID_BOTH} id_mode_t;
endpackage : flash_cmd_pkg

// ==== verification/spi_host_model.sv ====
// spi host model driving select, serial clock and data toward the flash
`timescale 1ns/100ps
module spi_host_model (
  input logic so_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // clock runs only inside frames, 80 ns period; data changes after falling edges
  task automatic xfer(input logic [63:0] tx, input int n, output logic [63:0] rx);
    rx = '0;
    #13 cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o = tx[63 - i];
      #40 sclk_o = 1'b1;
      rx = {rx[62:0], so_i};
      #40 sclk_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    // a released line must not keep showing its last bit
    si_o = ~si_o;
  endtask : xfer
endmodule : spi_host_model

// ==== verification/test_serial_flash_erase_power_id_cmds.sv ====
// self-checking bench for the erase, deep sleep and id sequencer
`timescale 1ns/100ps
module test_serial_flash_erase_power_id_cmds;
  import flash_cmd_pkg::*;
  localparam int E32 = 20;
  localparam int E64 = 30;
  localparam int EALL = 400;
  localparam int LIMIT = 60000;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic latch_set_i = 1'b0;
  logic [4:0] bp = 5'h00;
  logic sclk, cs_n, si, so, so_oe, busy, wl, ds, done, drop;
  erase_kind_t kind;
  logic [23:0] eaddr;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  int rise_cyc = 0;
  int busy_len = 0;
  int drop_cnt = 0;
  int done_cnt = 0;
  int oe_cnt = 0;
  logic busy_d = 1'b0;
  logic lat = 1'b0;
  logic [31:0] seed = 32'h81df02d7;
  logic [63:0] rx;

  always #10 core_clk_i = ~core_clk_i;

  flash_erase_power_seq #(.ERASE_32K_CYCLES(E32), .ERASE_64K_CYCLES(E64), .ARRAY_ERASE_CYCLES(EALL)) dut_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_si_i(si),
    .latch_set_i(latch_set_i), .protect_bit_0_i(bp[0]), .protect_bit_1_i(bp[1]), .protect_bit_2_i(bp[2]),
    .protect_bit_3_i(bp[3]), .protect_bit_4_i(bp[4]), .spi_so_o(so), .spi_so_oe_o(so_oe),
    .busy_flag_o(busy), .write_latch_flag_o(wl), .deep_sleep_o(ds), .erase_kind_o(kind),
    .erase_addr_o(eaddr), .erase_done_o(done), .cmd_drop_o(drop));

  spi_host_model host_u (.so_i(so), .sclk_o(sclk), .cs_n_o(cs_n), .si_o(si));

  // edge-sampled monitor; busy length is the distance between rise and fall
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    busy_d <= busy;
    if (busy && !busy_d) rise_cyc <= cyc;
    if (!busy && busy_d) busy_len <= cyc - rise_cyc;
    drop_cnt <= drop_cnt + (drop ? 1 : 0);
    done_cnt <= done_cnt + (done ? 1 : 0);
    oe_cnt <= oe_cnt + (so_oe ? 1 : 0);
    if (cyc == LIMIT) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #2;
  endtask : tick

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic int exp_len(input logic [7:0] op);
    return (op == OP_ERASE_32K || op == OP_ERASE_64K) ? 32 : 8;
  endfunction : exp_len

  function automatic erase_kind_t exp_kind(input logic [7:0] op);
    return op == OP_ERASE_32K ? ERASE_BLK32 : op == OP_ERASE_64K ? ERASE_BLK64 : ERASE_ALL;
  endfunction : exp_kind

  function automatic int exp_cyc(input logic [7:0] op);
    return op == OP_ERASE_32K ? E32 : op == OP_ERASE_64K ? E64 : EALL;
  endfunction : exp_cyc

  // top or bottom 2^(low-1) of the 32 big blocks, one if bit 4; a half block shares its big block
  function automatic logic guarded(input logic [7:0] op, input logic [23:0] a, input logic [4:0] p);
    int cnt;
    cnt = (p[2:0] == 3'h0) ? 0 : p[4] ? 1 : 1 << (p[2:0] - 3'h1);
    if (exp_len(op) == 8) return p[2:0] != 3'h0;
    return p[3] ? (int'(a[20:16]) < cnt) : (int'(a[20:16]) >= 32 - cnt);
  endfunction : guarded

  task automatic frame(input logic [63:0] w, input int n);
    host_u.xfer(w, n, rx);
    tick(8);
  endtask : frame

  task automatic erase(input logic [7:0] op, input logic [23:0] a, input int n, input logic set,
                       input logic may);
    int d0;
    int e0;
    logic ok;
    if (set) begin
      latch_set_i = 1'b1;
      tick(1);
      latch_set_i = 1'b0;
      lat = 1'b1;
    end
    tick(1);
    chk(wl, lat, "latch");
    ok = may && lat && n == exp_len(op) && !guarded(op, a, bp);
    d0 = drop_cnt;
    e0 = done_cnt;
    frame({op, a, 32'h0}, n);
    chk(busy, ok, "busy");
    if (ok) begin
      chk(kind, exp_kind(op), "kind");
      if (n == 32) chk(eaddr, a, "addr");
      chk(wl, 1'b0, "latch");
      for (int i = 0; i < EALL + 50 && busy; i++) tick(1);
      tick(2);
      chk(busy_len, exp_cyc(op), "busy length");
      chk(done_cnt - e0, 32'h1, "done");
      chk(ds, 1'b0, "sleep");
      lat = 1'b0;
    end else begin
      chk(drop_cnt - d0, 32'h1, "drop");
      chk(done_cnt - e0, 32'h0, "done");
    end
  endtask : erase

  initial begin
    logic [7:0] ops [4];
    logic [31:0] r;
    logic [31:0] a;
    int d0;
    int o0;
    ops = '{OP_ERASE_32K, OP_ERASE_64K, OP_ERASE_ALL_A, OP_ERASE_ALL_B};
    tick(20);
    rst_i = 1'b0;
    tick(4);
    chk(ds, 1'b0, "sleep");
    for (int k = 0; k < 4; k++) erase(ops[k], 24'h0abcde, exp_len(ops[k]), 1'b1, 1'b1);
    bp = 5'h01;
    erase(OP_ERASE_64K, 24'h1f0000, 32, 1'b1, 1'b1);
    erase(OP_ERASE_32K, 24'h1effff, 32, 1'b0, 1'b1);
    erase(OP_ERASE_ALL_A, 24'h000000, 8, 1'b0, 1'b1);
    for (int i = 0; i < 24; i++) begin
      r = rnd();
      a = rnd();
      bp = r[4] ? {r[9], r[8], r[7:5]} : {r[9], 4'h0};
      erase(ops[r[1:0]], a[23:0], exp_len(ops[r[1:0]]) + ((r[10] & r[11]) ? 1 : 0), r[12] | r[13], 1'b1);
    end
    bp = 5'h00;
    d0 = drop_cnt;
    frame({OP_SLEEP, 56'h0}, 9);
    tick(160);
    chk(drop_cnt - d0, 32'h1, "drop");
    chk(ds, 1'b0, "sleep");
    frame({OP_SLEEP, 56'h0}, 8);
    tick(100);
    chk(ds, 1'b0, "sleep");
    tick(60);
    chk(ds, 1'b1, "sleep");
    o0 = oe_cnt;
    erase(OP_ERASE_32K, 24'h000100, 32, 1'b1, 1'b0);
    frame({OP_MAKER_ID, 56'h0}, 56);
    chk(oe_cnt - o0, 32'h0, "drive");
    frame({OP_WAKE_ID, 56'h0}, 8);
    chk(ds, 1'b0, "sleep");
    erase(OP_ERASE_ALL_B, 24'h000000, 8, 1'b0, 1'b0);
    tick(160); // host keeps select high through recovery
    erase(OP_ERASE_ALL_B, 24'h000000, 8, 1'b0, 1'b1);
    latch_set_i = 1'b1;
    tick(1);
    latch_set_i = 1'b0;
    frame({OP_ERASE_ALL_A, 56'h0}, 8);
    d0 = drop_cnt;
    o0 = oe_cnt;
    frame({OP_SLEEP, 56'h0}, 8);
    frame({OP_WAKE_ID, 56'h0}, 56);
    for (int i = 0; i < EALL && busy; i++) tick(1);
    tick(2);
    chk(busy_len, EALL, "busy length");
    chk(drop_cnt - d0, 32'h1, "drop");
    chk(oe_cnt - o0, 32'h0, "drive");
    tick(200);
    chk(ds, 1'b0, "sleep");
    lat = 1'b0;
    frame({OP_WAKE_ID, 56'h0}, 56);
    chk(rx[23:0], {3{DEVICE_ID_DEFAULT}}, "device id");
    tick(160);
    frame({OP_MAKER_ID, 56'h0}, 56);
    chk(rx[23:0], {MAKER_ID_DEFAULT, DEVICE_ID_DEFAULT, MAKER_ID_DEFAULT}, "ids");
    frame({OP_MAKER_ID, ADDR_ID_SWAP, 32'h0}, 56);
    chk(rx[23:0], {DEVICE_ID_DEFAULT, MAKER_ID_DEFAULT, DEVICE_ID_DEFAULT}, "ids");
    // release alone while awake still runs the recovery, so an erase inside it is refused
    frame({OP_WAKE_ID, 56'h0}, 8);
    erase(OP_ERASE_ALL_B, 24'h000000, 8, 1'b1, 1'b0);
    tick(160);
    frame({OP_SLEEP, 56'h0}, 8);
    tick(160);
    chk(ds, 1'b1, "sleep");
    rst_i = 1'b1;
    tick(20);
    rst_i = 1'b0;
    lat = 1'b0;
    tick(4);
    chk(ds, 1'b0, "sleep");
    erase(OP_ERASE_32K, 24'h0a0000, 32, 1'b1, 1'b1);
    end_of_test();
  end
endmodule : test_serial_flash_erase_power_id_cmds
